// >>> pkg/dpsram_pkg.sv
`default_nettype none
package dpsram_pkg;
   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int DATA_W = 36;
   localparam int LANES  = 4;
   localparam int LANE_W = 9;
   localparam int DEPTH  = 2 ** ADDR_W;
   localparam int NPORTS = 2;
   localparam int HI_W   = DATA_W - 32;

   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] word_t;
   typedef logic [LANES-1:0]  lane_t;

   localparam addr_t ADDR_ZERO    = 15'h0000;
   localparam addr_t ADDR_ONE     = 15'h0001;
   localparam lane_t LANE_NONE    = 4'h0;
   localparam lane_t LANE_ALL     = 4'hf;

   // ----------------------------------------------------------------
   // host read wait, in cycles after the edge that takes the address
   // ----------------------------------------------------------------
   localparam logic [1:0] FT_WAIT   = 2'h1;
   localparam logic [1:0] PIPE_WAIT = 2'h2;
   localparam logic [1:0] WAIT_LAST = 2'h1;

   // ----------------------------------------------------------------
   // host register map (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_ADDR     = 8'h04;
   localparam logic [7:0] REG_WDATA_LO = 8'h08;
   localparam logic [7:0] REG_WDATA_HI = 8'h0c;
   localparam logic [7:0] REG_RDATA_LO = 8'h10;
   localparam logic [7:0] REG_RDATA_HI = 8'h14;
   localparam logic [7:0] REG_STATUS   = 8'h18;

   localparam int CTRL_GO       = 0;
   localparam int CTRL_WRITE    = 1;
   localparam int CTRL_CONTINUE = 2;
   localparam int CTRL_CLEAR    = 3;
   localparam int CTRL_LATENCY  = 4;
   localparam int CTRL_CE_OFF   = 5;
   localparam int CTRL_LANE_LO  = 8;
   localparam int STATUS_BUSY   = 0;
   localparam int STATUS_DONE   = 1;

   // expand active-high lane enables to a bit mask of the word
   function automatic word_t lane_mask(input lane_t lanes);
      word_t m;
      m = '0;
      for (int i = 0; i < LANES; i++) begin
         m[i*LANE_W +: LANE_W] = {LANE_W{lanes[i]}};
      end
      return m;
   endfunction
endpackage
`default_nettype wire

// >>> pkg/sram_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sram_port_if;
   import dpsram_pkg::*;
   addr_t addr;
   logic  address_load_strobe_n;
   logic  count_advance_n;
   logic  counter_clear_n;
   logic  chip_enable_n;
   logic  write_read_n;
   logic  output_drive_n;
   logic  latency_select;
   lane_t byte_lane_select_n;
   word_t dq_host;
   logic  dq_host_oe;
   word_t dq_dev;
   lane_t dq_dev_oe;
   word_t dq;

   // shared data wire; an undriven lane reads low
   always_comb begin
      dq = '0;
      for (int i = 0; i < LANES; i++) begin
         if (dq_host_oe) begin
            dq[i*LANE_W +: LANE_W] = dq_host[i*LANE_W +: LANE_W];
         end else if (dq_dev_oe[i]) begin
            dq[i*LANE_W +: LANE_W] = dq_dev[i*LANE_W +: LANE_W];
         end
      end
   end

   modport host (output addr, address_load_strobe_n, count_advance_n, counter_clear_n,
                 chip_enable_n, write_read_n, output_drive_n, latency_select,
                 byte_lane_select_n, dq_host, dq_host_oe, input dq);
   modport dev  (input addr, address_load_strobe_n, count_advance_n, counter_clear_n,
                 chip_enable_n, write_read_n, output_drive_n, latency_select,
                 byte_lane_select_n, dq, output dq_dev, dq_dev_oe);
endinterface
`default_nettype wire

// >>> hdl/burst_counter.sv
`timescale 1ns/1ps
`default_nettype none
module burst_counter
   import dpsram_pkg::*;
(
   input  wire logic  clk_i,      // port clock
   input  wire logic  rst_i,      // sync reset, active high
   input  wire addr_t addr_i,     // external address
   input  wire logic  ads_n_i,    // address load strobe
   input  wire logic  count_advance_n_n_i,  // count advance
   input  wire logic  clr_n_i,    // counter clear
   input  wire logic  ce_n_i,     // chip enable
   output addr_t      acc_addr_o, // address used this cycle
   output addr_t      count_o     // counter contents
);
   addr_t count_reg;
   addr_t count_next;

   assign count_o = count_reg;

   // ----------------------------------------------------------------
   // address used by the access taken at this edge
   // ----------------------------------------------------------------
   always_comb begin
      if (!clr_n_i) begin
         acc_addr_o = ADDR_ZERO;
      end else if (!ads_n_i) begin
         acc_addr_o = addr_i;
      end else if (!count_advance_n_n_i) begin
         acc_addr_o = count_reg + ADDR_ONE;
      end else begin
         acc_addr_o = count_reg;
      end
   end

   // ----------------------------------------------------------------
   // counter update; clear beats everything, even a deselected port
   // ----------------------------------------------------------------
   always_comb begin
      if (!clr_n_i) begin
         count_next = ADDR_ZERO;
      end else if (ce_n_i) begin
         count_next = count_reg;
      end else if (!ads_n_i && !count_advance_n_n_i) begin
         count_next = addr_i;
      end else if (ads_n_i && !count_advance_n_n_i) begin
         count_next = count_reg + ADDR_ONE;
      end else begin
         count_next = count_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_reg <= ADDR_ZERO;
      end else begin
         count_reg <= count_next;
      end
   end
endmodule // burst_counter
`default_nettype wire

// >>> hdl/dpsram_device.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - strobe low selects the external address
// - counter loads when strobe and advance low
// - clear low makes address strobe ignored
// - advance low with strobe high increments counter each enabled edge
// - clear low makes count advance ignored
// - clear low zeroes counter at edge
// - clear wins over load and increment
// - data driven on reads only with drive enable
// - write-not-read low writes data into array
// - controller holds write-not-read high to read
// - latency select low gives flow-through output
// - latency select high adds output register
// - left lanes gate own byte reads/writes
// - works with continuous or gated clock
// - counter spans array and wraps to zero
// - chip enable high deselects port; only clear still acts
// - burst walks successive addresses until advance stops
module dpsram_device
   import dpsram_pkg::*;
(
   input  wire logic clk_i,       // clock of both ports
   input  wire logic rst_i,       // sync reset, active high
   sram_port_if.dev  left_port,   // left port, byte lanes in use
   sram_port_if.dev  right_port,  // right port, full word only
   output addr_t     left_count_o,  // left counter contents
   output addr_t     right_count_o  // right counter contents
);
   // ----------------------------------------------------------------
   // storage shared by both ports
   // ----------------------------------------------------------------
   word_t mem [0:DEPTH-1];

   // ----------------------------------------------------------------
   // port pins gathered into arrays, index 0 left, 1 right
   // ----------------------------------------------------------------
   addr_t pin_addr   [NPORTS];
   logic  pin_ads_n  [NPORTS];
   logic  pin_count_advance_n_n[NPORTS];
   logic  pin_clr_n  [NPORTS];
   logic  pin_ce_n   [NPORTS];
   logic  pin_rw_n   [NPORTS];
   logic  pin_oe_n   [NPORTS];
   logic  pin_lat    [NPORTS];
   lane_t pin_lanes  [NPORTS];
   word_t pin_dq     [NPORTS];

   addr_t acc_addr   [NPORTS];
   addr_t count      [NPORTS];
   logic  wr_en      [NPORTS];
   logic  rd_en      [NPORTS];

   word_t stage_data_reg [NPORTS];
   logic  stage_valid_reg[NPORTS];
   lane_t stage_lanes_reg[NPORTS];
   word_t out_data_reg   [NPORTS];
   lane_t out_oe_reg     [NPORTS];

   assign pin_addr[0]    = left_port.addr;
   assign pin_ads_n[0]   = left_port.address_load_strobe_n;
   assign pin_count_advance_n_n[0] = left_port.count_advance_n;
   assign pin_clr_n[0]   = left_port.counter_clear_n;
   assign pin_ce_n[0]    = left_port.chip_enable_n;
   assign pin_rw_n[0]    = left_port.write_read_n;
   assign pin_oe_n[0]    = left_port.output_drive_n;
   assign pin_lat[0]     = left_port.latency_select;
   assign pin_lanes[0]   = ~left_port.byte_lane_select_n;
   assign pin_dq[0]      = left_port.dq;

   assign pin_addr[1]    = right_port.addr;
   assign pin_ads_n[1]   = right_port.address_load_strobe_n;
   assign pin_count_advance_n_n[1] = right_port.count_advance_n;
   assign pin_clr_n[1]   = right_port.counter_clear_n;
   assign pin_ce_n[1]    = right_port.chip_enable_n;
   assign pin_rw_n[1]    = right_port.write_read_n;
   assign pin_oe_n[1]    = right_port.output_drive_n;
   assign pin_lat[1]     = right_port.latency_select;
   // the right port has no lane pins: every lane takes part
   assign pin_lanes[1]   = LANE_ALL;
   assign pin_dq[1]      = right_port.dq;

   // ----------------------------------------------------------------
   // outputs, each straight from a flip-flop
   // ----------------------------------------------------------------
   assign left_port.dq_dev     = out_data_reg[0];
   assign left_port.dq_dev_oe  = out_oe_reg[0];
   assign right_port.dq_dev    = out_data_reg[1];
   assign right_port.dq_dev_oe = out_oe_reg[1];
   assign left_count_o         = count[0];
   assign right_count_o        = count[1];

   // merge the enabled lanes of new data into an old word
   function automatic word_t merge_lanes(input word_t old_w, input word_t new_w, input lane_t lanes);
      word_t m;
      m = lane_mask(lanes);
      return (old_w & ~m) | (new_w & m);
   endfunction

   // ----------------------------------------------------------------
   // per-port address path, access decode and read pipeline
   // ----------------------------------------------------------------
   for (genvar p = 0; p < NPORTS; p++) begin : g_port
      word_t out_data_next;
      logic  out_valid;
      lane_t out_lanes;

      burst_counter u_counter (
         .clk_i      (clk_i),
         .rst_i      (rst_i),
         .addr_i     (pin_addr[p]),
         .ads_n_i    (pin_ads_n[p]),
         .count_advance_n_n_i  (pin_count_advance_n_n[p]),
         .clr_n_i    (pin_clr_n[p]),
         .ce_n_i     (pin_ce_n[p]),
         .acc_addr_o (acc_addr[p]),
         .count_o    (count[p])
      );

      // a deselected port neither writes nor reads
      assign wr_en[p] = !pin_ce_n[p] && !pin_rw_n[p];
      assign rd_en[p] = !pin_ce_n[p] && pin_rw_n[p];

      // pipelined stage holds the word one clock longer
      always_ff @(posedge clk_i) begin
         stage_data_reg[p] <= mem[acc_addr[p]];
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            stage_valid_reg[p] <= 1'b0;
            stage_lanes_reg[p] <= LANE_NONE;
         end else begin
            stage_valid_reg[p] <= rd_en[p];
            stage_lanes_reg[p] <= pin_lanes[p];
         end
      end

      // flow-through takes the array word at the same edge
      always_comb begin
         if (pin_lat[p]) begin
            out_data_next = stage_data_reg[p];
            out_valid     = stage_valid_reg[p];
            out_lanes     = stage_lanes_reg[p];
         end else begin
            out_data_next = mem[acc_addr[p]];
            out_valid     = rd_en[p];
            out_lanes     = pin_lanes[p];
         end
      end

      always_ff @(posedge clk_i) begin
         out_data_reg[p] <= out_data_next;
      end

      // lanes drive only for a live read with drive enable low;
      // the drive enable is sampled, so it acts one edge late
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            out_oe_reg[p] <= LANE_NONE;
         end else if (out_valid && !pin_oe_n[p]) begin
            out_oe_reg[p] <= out_lanes;
         end else begin
            out_oe_reg[p] <= LANE_NONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // array write; no state counts on free-running edges, so a
   // gated clock only pauses the ports
   // ----------------------------------------------------------------
   // the right port is written first so that the left port wins a
   // same-address collision in the same cycle
   always_ff @(posedge clk_i) begin
      for (int p = NPORTS - 1; p >= 0; p--) begin
         if (wr_en[p]) begin
            mem[acc_addr[p]] <= merge_lanes(mem[acc_addr[p]], pin_dq[p], pin_lanes[p]);
         end
      end
   end
endmodule // dpsram_device
`default_nettype wire

// >>> hdl/dpsram_host.sv
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dpsram_host
   import dpsram_pkg::*;
(
   input  wire logic        clk_i,     // clock
   input  wire logic        rst_i,     // sync reset, active high
   input  wire logic        wb_cyc_i,  // wishbone cycle
   input  wire logic        wb_stb_i,  // wishbone strobe
   input  wire logic        wb_we_i,   // wishbone write
   input  wire logic [7:0]  wb_adr_i,  // byte address
   input  wire logic [3:0]  wb_sel_i,  // byte enables
   input  wire logic [31:0] wb_dat_i,  // write data
   output logic      [31:0] wb_dat_o,  // read data
   output logic             wb_ack_o,  // acknowledge
   sram_port_if.host        port       // memory port pins
);
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ISSUE = 3'b010,
      ST_WAIT  = 3'b100
   } state_e;

   state_e      state_reg;
   logic [31:0] ctrl_reg;
   addr_t       addr_reg;
   word_t       wdata_reg;
   word_t       rdata_reg;
   logic        done_reg;
   logic [1:0]  wait_reg;
   logic        req;
   logic        wr_take;
   logic        start;
   logic [31:0] ctrl_wdata;

   function automatic logic [31:0] apply_sel(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_w;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // wishbone slave: ack one cycle after the request
   // ----------------------------------------------------------------
   assign req     = wb_cyc_i && wb_stb_i;
   assign wr_take = req && wb_we_i && wb_ack_o;
   assign start   = wr_take && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_GO]
                    && state_reg == ST_IDLE;
   // the go write lands at the same edge as start, so the issue takes the merged word
   assign ctrl_wdata = apply_sel(ctrl_reg, wb_dat_i, wb_sel_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req && !wb_ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_ack_o) begin
         unique case (wb_adr_i)
            REG_CTRL:     wb_dat_o <= ctrl_reg;
            REG_ADDR:     wb_dat_o <= 32'(addr_reg);
            REG_WDATA_LO: wb_dat_o <= wdata_reg[31:0];
            REG_WDATA_HI: wb_dat_o <= 32'(wdata_reg[DATA_W-1:32]);
            REG_RDATA_LO: wb_dat_o <= rdata_reg[31:0];
            REG_RDATA_HI: wb_dat_o <= 32'(rdata_reg[DATA_W-1:32]);
            REG_STATUS:   wb_dat_o <= 32'({done_reg, state_reg != ST_IDLE});
            default:      wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg  <= 32'h0000_0000;
         addr_reg  <= ADDR_ZERO;
         wdata_reg <= '0;
      end else if (wr_take) begin
         unique case (wb_adr_i)
            REG_CTRL:     ctrl_reg <= apply_sel(ctrl_reg, wb_dat_i, wb_sel_i) & ~32'h0000_0001;
            REG_ADDR:     addr_reg <= ADDR_W'(apply_sel(32'(addr_reg), wb_dat_i, wb_sel_i));
            REG_WDATA_LO: wdata_reg[31:0] <= apply_sel(wdata_reg[31:0], wb_dat_i, wb_sel_i);
            REG_WDATA_HI: wdata_reg[DATA_W-1:32] <= HI_W'(apply_sel(32'(wdata_reg[DATA_W-1:32]),
                                                                     wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
   end

   // done is sticky; a new completion wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_reg <= 1'b0;
      end else if ((state_reg == ST_ISSUE && (ctrl_reg[CTRL_WRITE] || ctrl_reg[CTRL_CE_OFF]))
                   || (state_reg == ST_WAIT && wait_reg == WAIT_LAST)) begin
         done_reg <= 1'b1;
      end else if (wr_take && wb_adr_i == REG_STATUS && wb_sel_i[0] && wb_dat_i[STATUS_DONE]) begin
         done_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // port sequencer: one access per go, pins from flip-flops
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg                  <= ST_IDLE;
         wait_reg                   <= FT_WAIT;
         rdata_reg                  <= '0;
         port.addr                  <= ADDR_ZERO;
         port.address_load_strobe_n <= 1'b1;
         port.count_advance_n       <= 1'b1;
         port.counter_clear_n       <= 1'b1;
         port.chip_enable_n         <= 1'b1;
         port.write_read_n          <= 1'b1;
         port.output_drive_n        <= 1'b1;
         port.latency_select        <= 1'b0;
         port.byte_lane_select_n    <= LANE_ALL;
         port.dq_host               <= '0;
         port.dq_host_oe            <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  state_reg                  <= ST_ISSUE;
                  wait_reg                   <= ctrl_wdata[CTRL_LATENCY] ? PIPE_WAIT : FT_WAIT;
                  port.addr                  <= addr_reg;
                  port.address_load_strobe_n <= ctrl_wdata[CTRL_CONTINUE];
                  port.count_advance_n       <= 1'b0;
                  port.counter_clear_n       <= !ctrl_wdata[CTRL_CLEAR];
                  port.chip_enable_n         <= ctrl_wdata[CTRL_CE_OFF];
                  port.write_read_n          <= !ctrl_wdata[CTRL_WRITE];
                  port.output_drive_n        <= ctrl_wdata[CTRL_WRITE];
                  port.latency_select        <= ctrl_wdata[CTRL_LATENCY];
                  port.byte_lane_select_n    <= ~ctrl_wdata[CTRL_LANE_LO +: LANES];
                  port.dq_host               <= wdata_reg;
                  port.dq_host_oe            <= ctrl_wdata[CTRL_WRITE];
               end
            end
            ST_ISSUE: begin
               port.address_load_strobe_n <= 1'b1;
               port.count_advance_n       <= 1'b1;
               port.counter_clear_n       <= 1'b1;
               port.chip_enable_n         <= 1'b1;
               port.write_read_n          <= 1'b1;
               port.dq_host_oe            <= 1'b0;
               if (ctrl_reg[CTRL_WRITE] || ctrl_reg[CTRL_CE_OFF]) begin
                  state_reg           <= ST_IDLE;
                  port.output_drive_n <= 1'b1;
               end else begin
                  state_reg <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (wait_reg == WAIT_LAST) begin
                  rdata_reg           <= port.dq;
                  port.output_drive_n <= 1'b1;
                  state_reg           <= ST_IDLE;
               end else begin
                  wait_reg <= wait_reg - WAIT_LAST;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // dpsram_host
`default_nettype wire

// >>> tb/dpsram_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dpsram_link_sva
   import dpsram_pkg::*;
(
   input wire logic  clk_i,                 // clock
   input wire logic  rst_i,                 // sync reset
   input wire addr_t addr,                  // address pins
   input wire logic  address_load_strobe_n, // load strobe
   input wire logic  count_advance_n,       // count advance
   input wire logic  counter_clear_n,       // counter clear
   input wire logic  chip_enable_n,         // chip enable
   input wire logic  write_read_n,          // direction
   input wire logic  output_drive_n,        // drive enable
   input wire logic  latency_select,        // latency
   input wire lane_t byte_lane_select_n,    // lanes
   input wire logic  dq_host_oe,            // host drive
   input wire lane_t dq_dev_oe,             // device drive
   input wire addr_t left_count_o           // counter
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic rd = !chip_enable_n && write_read_n;
   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   chk_clear_zero: assert property (!counter_clear_n |=> left_count_o == ADDR_ZERO)
      else $error("counter not cleared");
   chk_load_addr: assert property (!chip_enable_n && counter_clear_n && !address_load_strobe_n
      && !count_advance_n |=> left_count_o == $past(addr)) else $error("counter not loaded");
   chk_inc_one: assert property (!chip_enable_n && counter_clear_n && address_load_strobe_n
      && !count_advance_n |=> left_count_o == addr_t'($past(left_count_o) + ADDR_ONE))
      else $error("counter not advanced by one");
   chk_hold_count: assert property (counter_clear_n && (chip_enable_n || count_advance_n)
      |=> $stable(left_count_o)) else $error("counter moved while held");
   // ----------------------------------------------------------------
   // data drive
   // ----------------------------------------------------------------
   chk_drive_gate: assert property (dq_dev_oe != LANE_NONE |-> !$past(output_drive_n))
      else $error("data driven without drive enable");
   chk_ce_quiet: assert property (chip_enable_n [*2] |=> dq_dev_oe == LANE_NONE)
      else $error("deselected port drives data");
   chk_ft_lanes: assert property (rd && !latency_select && !output_drive_n
      |=> dq_dev_oe == ~$past(byte_lane_select_n)) else $error("flow-through output wrong");
   chk_pipe_lanes: assert property (rd && latency_select ##1 !output_drive_n && $stable(byte_lane_select_n)
      |=> dq_dev_oe == ~$past(byte_lane_select_n)) else $error("pipelined output wrong");
   chk_host_dir: assert property (dq_host_oe |-> !write_read_n)
      else $error("host drives data on a read");
   cover property (rd && latency_select);
   cover property (!counter_clear_n);
   cover property (!chip_enable_n && !write_read_n && byte_lane_select_n != LANE_NONE);
endmodule // dpsram_link_sva
`default_nettype wire

// >>> tb/dual_port_sram_port_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dual_port_sram_port_control_tb_top;
   import dpsram_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [1:0]  cyc = 2'h0;
   logic [1:0]  we = 2'h0;
   logic [1:0]  ack;
   logic [7:0]  adr [2] = '{8'h00, 8'h00};
   logic [3:0]  sel [2] = '{4'hf, 4'hf};
   logic [31:0] dw [2] = '{32'h0, 32'h0};
   logic [31:0] dr [2];
   addr_t       lcnt;
   addr_t       rcnt;
   int          fails = 0;
   int          checked = 0;
   int          cycles = 0;
   word_t       q;
   sram_port_if p [2] ();
   dpsram_device i_dpsram_device (.clk_i(clk_i), .rst_i(rst_i), .left_port(p[0]), .right_port(p[1]),
      .left_count_o(lcnt), .right_count_o(rcnt));
   for (genvar g = 0; g < 2; g++) begin : h
      dpsram_host i_dpsram_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc[g]), .wb_stb_i(cyc[g]),
         .wb_we_i(we[g]), .wb_adr_i(adr[g]), .wb_sel_i(sel[g]), .wb_dat_i(dw[g]), .wb_dat_o(dr[g]),
         .wb_ack_o(ack[g]), .port(p[g]));
   end
   dpsram_link_sva i_dpsram_link_sva (.clk_i(clk_i), .rst_i(rst_i), .addr(p[0].addr),
      .address_load_strobe_n(p[0].address_load_strobe_n), .count_advance_n(p[0].count_advance_n),
      .counter_clear_n(p[0].counter_clear_n), .chip_enable_n(p[0].chip_enable_n),
      .write_read_n(p[0].write_read_n), .output_drive_n(p[0].output_drive_n),
      .latency_select(p[0].latency_select), .byte_lane_select_n(p[0].byte_lane_select_n),
      .dq_host_oe(p[0].dq_host_oe), .dq_dev_oe(p[0].dq_dev_oe), .left_count_o(lcnt));
   always #2 clk_i = ~clk_i;
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      if (fails == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input word_t e, input word_t s);
      checked++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one classic cycle; waits for ack, bounded by the run timeout
   task automatic wb(input int i, input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      @(posedge clk_i);
      cyc[i] <= 1'b1;
      we[i] <= w;
      adr[i] <= a;
      dw[i] <= d;
      do @(posedge clk_i); while (ack[i] !== 1'b1);
      r = dr[i];
      cyc[i] <= 1'b0;
   endtask
   task automatic op(input int i, input logic [11:0] c, input addr_t a, input word_t d, output word_t r);
      logic [31:0] s, lo, hi;
      wb(i, 1'b1, REG_ADDR, 32'(a), s);
      wb(i, 1'b1, REG_WDATA_LO, d[31:0], s);
      wb(i, 1'b1, REG_WDATA_HI, 32'(d[35:32]), s);
      wb(i, 1'b1, REG_CTRL, {20'h0, c} | 32'h1, s);
      do wb(i, 1'b0, REG_STATUS, 32'h0, s); while (s[STATUS_DONE] !== 1'b1);
      wb(i, 1'b1, REG_STATUS, 32'h2, s);
      wb(i, 1'b0, REG_RDATA_LO, 32'h0, lo);
      wb(i, 1'b0, REG_RDATA_HI, 32'h0, hi);
      r = {hi[HI_W-1:0], lo};
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_rw();
      op(0, 12'hf02, 15'h0055, 36'h912345678, q);
      op(1, 12'hf00, 15'h0055, 36'h0, q);
      chk("right flow-through read", 36'h912345678, q);
      chk("right loaded count", 36'(15'h0055), 36'(rcnt));
      op(0, 12'hf10, 15'h0055, 36'h0, q);
      chk("left pipelined read", 36'h912345678, q);
   endtask
   task automatic t_lanes();
      op(0, 12'h502, 15'h0055, 36'h6edcba987, q);
      op(1, 12'hf00, 15'h0055, 36'h0, q);
      chk("lane merged word", 36'h915c85787, q);
      op(0, 12'h200, 15'h0055, 36'h0, q);
      chk("single lane read", 36'h000005600, q);
   endtask
   task automatic t_counter();
      op(0, 12'hf00, 15'h0123, 36'h0, q);
      chk("loaded count", 36'(15'h0123), 36'(lcnt));
      op(0, 12'hf06, 15'h0000, 36'h5a5a50f0f, q);
      chk("advanced count", 36'(15'h0124), 36'(lcnt));
      op(1, 12'hf00, 15'h0124, 36'h0, q);
      chk("burst write word", 36'h5a5a50f0f, q);
      op(0, 12'hf08, 15'h0123, 36'h0, q);
      chk("cleared count", 36'h0, 36'(lcnt));
      op(0, 12'hf00, 15'h7fff, 36'h0, q);
      op(0, 12'hf04, 15'h0000, 36'h0, q);
      chk("wrapped count", 36'h0, 36'(lcnt));
   endtask
   task automatic t_ce_off();
      op(0, 12'hf22, 15'h0124, 36'h912345678, q);
      chk("held count", 36'h0, 36'(lcnt));
      op(1, 12'hf00, 15'h0124, 36'h0, q);
      chk("deselected write", 36'h5a5a50f0f, q);
   endtask
   task automatic t_unmapped();
      logic [31:0] s;
      wb(0, 1'b1, 8'h40, 32'hffffffff, s);
      wb(0, 1'b0, 8'h40, 32'h0, s);
      chk("unmapped read", 36'h0, 36'(s));
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_rw();
      t_lanes();
      t_counter();
      t_ce_off();
      t_unmapped();
      tally_and_finish();
   end
endmodule // dual_port_sram_port_control_tb_top
`default_nettype wire
